// file: hdl/mcl_config_loader.sv
// Fuse-store loader and burner feeding the live converter configuration registers.
//
// Contract
// - Ready 100us after VCC reset release.
// - Power-up copies fuse data into live registers.
// - Copy only when fuse store was programmed.
// - Enable toggles never repeat the copy.
// - Fuse store burned at most three times.
// - Host register writes take effect immediately.
// - Converters off during burn, restart afterwards.
// - Burn request locks writes, reads still allowed.
// - Low burn supply aborts and unlocks.
// - Burn stores 16-bit checksum with the data.
// - Wait 100ms, clear request, release lock.
// - Power-up checksum match loads, else defaults.
// - Readable flag reports power-up checksum mismatch.
`timescale 1ns/1ns
module mcl_config_loader
  import mcl_pkg::*;
#(
  parameter int READY_CYCLES_P = READY_CYCLES,
  parameter int HOLD_CYCLES_P = HOLD_CYCLES,
  parameter logic [NUM_REGS*8-1:0] DEFAULT_REGS = '0
) (
  // Clock and the VCC-rise reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Enable pin level.
  input wire logic enableSyncInput,
  // Host register access and status.
  input wire mcl_host_req_s hostReq,
  input wire logic hostBurnReq,
  output logic [7:0] hostRdData,
  output logic blockReady,
  output logic burnRequestBit,
  output logic writeLock,
  output logic csumError,
  output logic [1:0] burnCount,
  output logic burnAbort,
  // Fuse macro.
  output logic [FUSE_AW-1:0] fuseAddr,
  input wire logic [7:0] fuseRdData,
  output mcl_fuse_wr_s fuseWr,
  input wire logic fuseWrReady,
  input wire logic burnSupplyOk,
  // Converter side.
  output logic [NUM_REGS*8-1:0] liveRegs,
  output logic convEnable,
  output logic seqStart
);

  // Controller state, index into the fuse store and running checksum.
  mcl_state_e state_reg, state_next;
  logic [FUSE_AW-1:0] idx_reg, idx_next;
  logic [15:0] csum_reg, csum_next;
  logic [15:0] stored_reg, stored_next; // Checksum read back from the fuse store.
  logic [TIMER_W-1:0] timer_reg, timer_next; // Shared by the ready delay and the hold wait.
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] regs_next [NUM_REGS];
  logic burnBit_reg, burnBit_next;
  logic csumErr_reg, csumErr_next;
  logic [1:0] count_reg, count_next;
  logic [7:0] rdData_reg, rdData_next;
  logic seqStart_reg, seqStart_next;
  logic abort_reg, abort_next;
  logic burning; // Any phase of a burn, supply check included.

  assign burning = (state_reg == ST_SUPPLY) || (state_reg == ST_BURN) || (state_reg == ST_HOLD);

  // Next-state logic for the whole controller.
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    csum_next = csum_reg;
    stored_next = stored_reg;
    timer_next = timer_reg;
    regs_next = regs_reg;
    burnBit_next = burnBit_reg;
    csumErr_next = csumErr_reg;
    count_next = count_reg;
    seqStart_next = 1'b0;
    abort_next = 1'b0;
    rdData_next = regs_reg[hostReq.addr];
    unique case (state_reg)
      ST_WAIT: begin
        // Nothing happens until the supply has settled.
        if (timer_reg == '0) begin
          state_next = ST_LOAD;
          idx_next = '0;
          csum_next = CSUM_SEED;
        end else begin
          timer_next = timer_reg - 1'b1;
        end
      end
      ST_LOAD: begin
        // Fuse reads are combinational on the address, one byte per cycle.
        if (idx_reg < FUSE_CSUM_LO) begin
          regs_next[idx_reg[REG_AW-1:0]] = fuseRdData;
          csum_next = mcl_csum_step(csum_reg, fuseRdData);
        end
        if (idx_reg == FUSE_CSUM_LO) begin
          stored_next[7:0] = fuseRdData;
        end
        if (idx_reg == FUSE_CSUM_HI) begin
          stored_next[15:8] = fuseRdData;
        end
        if (idx_reg == FUSE_COUNT) begin
          count_next = fuseRdData[1:0];
          state_next = ST_CHECK;
        end
        idx_next = idx_reg + 1'b1;
      end
      ST_CHECK: begin
        // Unprogrammed or corrupt store falls back to the built-in defaults.
        if ((count_reg == 2'h0) || (csum_reg != stored_reg)) begin
          for (int i = 0; i < NUM_REGS; i++) begin
            regs_next[i] = DEFAULT_REGS[i*8 +: 8];
          end
        end
        csumErr_next = (count_reg != 2'h0) && (csum_reg != stored_reg);
        state_next = ST_IDLE;
      end
      ST_IDLE: begin
        // Only a new reset leads back to the load states; the enable pin does not.
        if (hostBurnReq) begin
          burnBit_next = 1'b1;
          state_next = ST_SUPPLY;
        end else if (hostReq.wrEn) begin
          regs_next[hostReq.addr] = hostReq.data;
        end
      end
      ST_SUPPLY: begin
        // A burn with low supply or no burns left is dropped and the lock released.
        if (burnSupplyOk && (count_reg < MAX_BURNS)) begin
          state_next = ST_BURN;
          idx_next = '0;
          csum_next = CSUM_SEED;
        end else begin
          burnBit_next = 1'b0;
          abort_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_BURN: begin
        // One byte per accepted fuse write: data, checksum low, high, then count.
        if (fuseWrReady) begin
          if (idx_reg < FUSE_CSUM_LO) begin
            csum_next = mcl_csum_step(csum_reg, regs_reg[idx_reg[REG_AW-1:0]]);
          end
          if (idx_reg == FUSE_COUNT) begin
            count_next = count_reg + 1'b1;
            timer_next = TIMER_W'(HOLD_CYCLES_P - 1);
            state_next = ST_HOLD;
          end
          idx_next = idx_reg + 1'b1;
        end
      end
      ST_HOLD: begin
        // Settle time after the fuse write before the host sees completion.
        if (timer_reg == '0) begin
          burnBit_next = 1'b0;
          seqStart_next = 1'b1;
          state_next = ST_IDLE;
        end else begin
          timer_next = timer_reg - 1'b1;
        end
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  // Controller registers; reset is the VCC rise, so this restarts the power-up load.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_WAIT;
      idx_reg <= '0;
      csum_reg <= CSUM_SEED;
      stored_reg <= 16'h0000;
      timer_reg <= TIMER_W'(READY_CYCLES_P - 1);
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= 8'h00;
      end
      burnBit_reg <= 1'b0;
      csumErr_reg <= 1'b0;
      count_reg <= 2'h0;
      rdData_reg <= 8'h00;
      seqStart_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      csum_reg <= csum_next;
      stored_reg <= stored_next;
      timer_reg <= timer_next;
      regs_reg <= regs_next;
      burnBit_reg <= burnBit_next;
      csumErr_reg <= csumErr_next;
      count_reg <= count_next;
      rdData_reg <= rdData_next;
      seqStart_reg <= seqStart_next;
      abort_reg <= abort_next;
    end
  end

  // Live registers drive the converters directly.
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_live
    assign liveRegs[g*8 +: 8] = regs_reg[g];
  end

  // Fuse write data comes from the live copy, the running checksum or the incremented burn count.
  always_comb begin
    fuseWr.wrReq = (state_reg == ST_BURN);
    fuseWr.addr = idx_reg;
    if (idx_reg < FUSE_CSUM_LO) begin
      fuseWr.data = regs_reg[idx_reg[REG_AW-1:0]];
    end else if (idx_reg == FUSE_CSUM_LO) begin
      fuseWr.data = csum_reg[7:0];
    end else if (idx_reg == FUSE_CSUM_HI) begin
      fuseWr.data = csum_reg[15:8];
    end else begin
      fuseWr.data = {6'h00, count_reg + 2'h1};
    end
  end

  assign fuseAddr = idx_reg;
  assign blockReady = (state_reg != ST_WAIT) && (state_reg != ST_LOAD) && (state_reg != ST_CHECK);
  assign writeLock = burnBit_reg || !blockReady;
  assign convEnable = enableSyncInput && blockReady && !burning;
  assign hostRdData = rdData_reg;
  assign burnRequestBit = burnBit_reg;
  assign csumError = csumErr_reg;
  assign burnCount = count_reg;
  assign burnAbort = abort_reg;
  assign seqStart = seqStart_reg;

  // Checks on the controller behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ready_delay: assert property ($rose(blockReady) |-> $past(state_reg == ST_CHECK))
    else $error("block ready without finishing the power-up load");
  a_no_reload: assert property (blockReady |=> blockReady)
    else $error("power-up load repeated without reset");
  a_write_now: assert property ((state_reg == ST_IDLE) && !hostBurnReq && hostReq.wrEn
    |=> regs_reg[$past(hostReq.addr)] == $past(hostReq.data))
    else $error("host write did not take effect");
  a_write_locked: assert property (writeLock && blockReady && hostReq.wrEn
    |=> $stable(liveRegs))
    else $error("live register changed while locked");
  a_supply_abort: assert property ((state_reg == ST_SUPPLY) && !burnSupplyOk
    |=> (state_reg == ST_IDLE) && !writeLock && burnAbort)
    else $error("low burn supply did not abort");
  a_burn_limit: assert property ((state_reg == ST_SUPPLY) && (count_reg == MAX_BURNS) |=> !burnRequestBit)
    else $error("fourth burn was started");
  a_conv_off: assert property (burnRequestBit |-> !convEnable)
    else $error("converters enabled during a burn");
  a_hold_release: assert property ((state_reg == ST_HOLD) && (timer_reg == '0)
    |=> !burnRequestBit && seqStart ##1 !seqStart)
    else $error("burn hold did not end cleanly");
  a_csum_flag: assert property ((state_reg == ST_CHECK) && (count_reg != 2'h0) && (csum_reg != stored_reg)
    |=> csumError && (liveRegs == DEFAULT_REGS))
    else $error("checksum mismatch not reported or defaults not loaded");
  a_csum_write: assert property (fuseWr.wrReq && (fuseWr.addr == FUSE_CSUM_LO) |-> fuseWr.data == csum_reg[7:0])
    else $error("checksum low byte wrong");

  c_power_load: cover property ($rose(blockReady));
  c_burn_done: cover property (seqStart);
  c_burn_abort: cover property (burnAbort);
  c_csum_bad: cover property ($rose(csumError));

endmodule

// file: hdl/mcl_pkg.sv
// Shared constants, types and checksum step for the fuse-store configuration loader.
package mcl_pkg;
  // Live register file shape.
  localparam int NUM_REGS = 16;
  localparam int REG_AW = 4;
  localparam int FUSE_AW = 5;
  // Fuse store layout: data bytes at 0..NUM_REGS-1, then checksum and burn count.
  localparam logic [4:0] FUSE_CSUM_LO = 5'h10;
  localparam logic [4:0] FUSE_CSUM_HI = 5'h11;
  localparam logic [4:0] FUSE_COUNT = 5'h12;
  // Most burns the fuse store accepts.
  localparam logic [1:0] MAX_BURNS = 2'h3;
  // Checksum start value.
  localparam logic [15:0] CSUM_SEED = 16'h0000;
  // Timing: clock rate and documented delays.
  localparam int CLK_MHZ = 250;
  localparam int READY_US = 100;
  localparam int READY_CYCLES = READY_US * CLK_MHZ;
  localparam int HOLD_MS = 100;
  localparam int HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W = 25;
  // Controller states, one-hot.
  typedef enum logic [6:0] {
    ST_WAIT = 7'h01,
    ST_LOAD = 7'h02,
    ST_CHECK = 7'h04,
    ST_IDLE = 7'h08,
    ST_SUPPLY = 7'h10,
    ST_BURN = 7'h20,
    ST_HOLD = 7'h40
  } mcl_state_e;
  // Host register access as passed in by the serial slave.
  typedef struct packed {
    logic wrEn;
    logic [REG_AW-1:0] addr;
    logic [7:0] data;
  } mcl_host_req_s;
  // Write request towards the fuse macro.
  typedef struct packed {
    logic wrReq;
    logic [FUSE_AW-1:0] addr;
    logic [7:0] data;
  } mcl_fuse_wr_s;
  // One checksum step: rotate left and add the byte, so order and value both count.
  function automatic logic [15:0] mcl_csum_step(input logic [15:0] acc, input logic [7:0] b);
    return {acc[14:0], acc[15]} + {8'h00, b};
  endfunction
endpackage

// file: bench/mcl_fuse_model.sv
// Behavioural fuse macro facing the loader, with prompt or stalled write acceptance.
`timescale 1ns/1ns
module mcl_fuse_model
  import mcl_pkg::*;
(
  // Clock and pace control.
  input wire logic clk,
  input wire logic slowMode,
  // Fuse port of the loader.
  input wire logic [FUSE_AW-1:0] fuseAddr,
  output logic [7:0] fuseRdData,
  input wire mcl_fuse_wr_s fuseWr,
  output logic fuseWrReady
);
  // Fuse cells; the bench presets them directly.
  logic [7:0] mem [0:31];
  // Pace toggle, so slow mode refuses writes on every other cycle.
  logic paceReg = 1'b0;
  // Reads are combinational, so the loader sees the byte in the same cycle.
  assign fuseRdData = mem[fuseAddr];
  // A stalled write must not land, which is why ready gates the store.
  assign fuseWrReady = !slowMode || paceReg;
  // Store each accepted byte.
  always @(posedge clk) begin
    paceReg <= !paceReg;
    if (fuseWr.wrReq && fuseWrReady) begin
      mem[fuseWr.addr] <= fuseWr.data;
    end
  end
endmodule

// file: bench/mcl_config_loader_test.sv
// Self-checking bench for the fuse-store loader and burner.
`timescale 1ns/1ns
module mcl_config_loader_test
  import mcl_pkg::*;
;
  // Short counts keep the run brief; expectations derive from them.
  localparam int RDY = 8;
  localparam int HLD = 16;
  localparam logic [127:0] DEF_REGS = 128'hA5A5_5A5A_0F0F_F0F0_1234_5678_9ABC_DEF0;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic enIn = 1'b0;
  mcl_host_req_s hostReq = '0;
  logic burnReq = 1'b0;
  logic supplyOk = 1'b1;
  logic slowMode = 1'b0;
  logic [7:0] rdData;
  logic blockReady, burnBit, writeLock, csumError, burnAbort, seqStart, convEnable, fuseWrReady;
  logic [1:0] burnCount;
  logic [FUSE_AW-1:0] fuseAddr;
  logic [7:0] fuseRdData;
  mcl_fuse_wr_s fuseWr;
  logic [127:0] liveRegs;
  // Expected live register image, tracked from host writes.
  logic [127:0] img = DEF_REGS;
  int errTotal = 0;
  int checksDone = 0;
  int cycles = 0;
  always #2 clk = !clk;
  mcl_config_loader #(.READY_CYCLES_P(RDY), .HOLD_CYCLES_P(HLD), .DEFAULT_REGS(DEF_REGS)) dut_u (
    .clk(clk), .sys_rst(sysRst), .enableSyncInput(enIn), .hostReq(hostReq), .hostBurnReq(burnReq),
    .hostRdData(rdData), .blockReady(blockReady), .burnRequestBit(burnBit), .writeLock(writeLock),
    .csumError(csumError), .burnCount(burnCount), .burnAbort(burnAbort), .fuseAddr(fuseAddr),
    .fuseRdData(fuseRdData), .fuseWr(fuseWr), .fuseWrReady(fuseWrReady), .burnSupplyOk(supplyOk),
    .liveRegs(liveRegs), .convEnable(convEnable), .seqStart(seqStart));
  mcl_fuse_model fuse_u (.clk(clk), .slowMode(slowMode), .fuseAddr(fuseAddr), .fuseRdData(fuseRdData),
    .fuseWr(fuseWr), .fuseWrReady(fuseWrReady));
  // Checksum written independently: rotate left by one, then add the byte.
  function automatic logic [15:0] sumOf(input logic [127:0] d);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < 16; i++) acc = {acc[14:0], acc[15]} + {8'h00, d[i*8+:8]};
    return acc;
  endfunction
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string msg);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Preset the fuse store; a bad flag spoils the stored checksum.
  task automatic loadFuse(input logic [127:0] d, input logic [1:0] cnt, input logic bad);
    logic [15:0] cs;
    cs = sumOf(d);
    for (int i = 0; i < 16; i++) fuse_u.mem[i] = d[i*8+:8];
    fuse_u.mem[16] = cs[7:0];
    fuse_u.mem[17] = cs[15:8] ^ {7'h00, bad};
    fuse_u.mem[18] = {6'h00, cnt};
  endtask
  // A VCC rise: reset, then the ready delay and the load.
  task automatic powerUp;
    sysRst = 1'b1;
    cyc(12);
    sysRst = 1'b0;
    // Ready follows the delay, nineteen fuse reads and one check cycle.
    cyc(RDY + 19);
    chk(blockReady, 1'b0, "ready too early");
    cyc(1);
    chk(blockReady, 1'b1, "never ready");
  endtask
  task automatic hostWrite(input logic [3:0] a, input logic [7:0] d);
    hostReq = {1'b1, a, d};
    cyc(1);
    hostReq.wrEn = 1'b0;
    // An idle edge keeps a following write from rewriting the strobe in one step.
    cyc(1);
  endtask
  task automatic pulseBurn;
    burnReq = 1'b1;
    cyc(1);
    burnReq = 1'b0;
  endtask
  task automatic tBlank;
    loadFuse('0, 2'h0, 1'b0);
    powerUp();
    chk(liveRegs, DEF_REGS, "blank store not defaults");
    chk(csumError, 1'b0, "blank store flagged");
    chk(writeLock, 1'b0, "lock after ready");
    $display("test blank done");
  endtask
  // Writes to address 3 and to the top of the map take effect in the next cycle.
  task automatic tWrite;
    hostWrite(4'h3, 8'hC4);
    hostWrite(4'hF, 8'h3E);
    img[31:24] = 8'hC4;
    img[127:120] = 8'h3E;
    hostReq.addr = 4'h3;
    cyc(1);
    chk(liveRegs, img, "write not live");
    chk(rdData, 8'hC4, "readback");
    $display("test write done");
  endtask
  task automatic tBurn;
    int len;
    enIn = 1'b1;
    slowMode = 1'b1;
    cyc(1);
    chk(convEnable, 1'b1, "converters off before burn");
    pulseBurn();
    chk(burnBit, 1'b1, "burn bit not set");
    chk(convEnable, 1'b0, "converters on in burn");
    hostWrite(4'h5, 8'h77);
    cyc(1);
    chk(liveRegs, img, "write during burn");
    chk(rdData, img[47:40], "read during burn");
    len = 3;
    for (int i = 0; i < 200 && burnBit === 1'b1; i++) begin
      cyc(1);
      len++;
    end
    chk(len >= HLD + 19, 1'b1, "hold too short");
    chk(seqStart, 1'b1, "no sequenced restart");
    chk(writeLock, 1'b0, "lock kept");
    chk(burnCount, 2'h1, "burn count");
    for (int i = 0; i < 16; i++) chk(fuse_u.mem[i], img[i*8+:8], "fuse data");
    chk({fuse_u.mem[17], fuse_u.mem[16]}, sumOf(img), "stored checksum");
    chk(fuse_u.mem[18], 8'h01, "stored count");
    slowMode = 1'b0;
    $display("test burn done");
  endtask
  // Reload the burned image; enable toggles must not reload it.
  task automatic tReload;
    powerUp();
    chk(liveRegs, img, "image not loaded");
    chk(csumError, 1'b0, "false mismatch");
    hostWrite(4'h0, 8'h99);
    img[7:0] = 8'h99;
    enIn = 1'b0;
    cyc(3);
    chk(convEnable, 1'b0, "enable ignored");
    enIn = 1'b1;
    cyc(3);
    chk(liveRegs, img, "enable toggle reloaded");
    $display("test reload done");
  endtask
  task automatic tCorrupt;
    loadFuse(img, 2'h1, 1'b1);
    powerUp();
    chk(liveRegs, DEF_REGS, "bad store loaded");
    chk(csumError, 1'b1, "mismatch not flagged");
    $display("test corrupt done");
  endtask
  // A refused burn: pulse of abort, unlock, writes work again.
  task automatic abortBurn;
    logic seen;
    seen = 1'b0;
    pulseBurn();
    for (int i = 0; i < 4; i++) begin
      if (burnAbort === 1'b1) seen = 1'b1;
      cyc(1);
    end
    chk(seen, 1'b1, "no abort");
    chk(burnBit, 1'b0, "burn bit kept");
    hostWrite(4'h2, 8'h11);
    cyc(1);
    chk(liveRegs[23:16], 8'h11, "still locked");
  endtask
  task automatic tAbort;
    supplyOk = 1'b0;
    abortBurn();
    supplyOk = 1'b1;
    loadFuse(img, 2'h3, 1'b0);
    powerUp();
    abortBurn();
    chk(fuse_u.mem[18], 8'h03, "fourth burn");
    $display("test abort done");
  endtask
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 3000) begin
      errTotal++;
      $display("[FAIL] %0t run did not finish in time", $time);
      endOfTest();
    end
  end
  initial begin
    tBlank();
    tWrite();
    tBurn();
    tReload();
    tCorrupt();
    tAbort();
    endOfTest();
  end
endmodule
